/* File: hdl/slot_cap2_pkg.sv */
// package with offsets, field positions and reset values of the slot status and cap2 slice
package slot_cap2_pkg;

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] SLOT_EVENT_OFS     = 8'hd8;
   localparam logic [7:0] DEV_CAP_TWO_OFS    = 8'he4;
   localparam logic [7:0] DEV_CTL_TWO_OFS    = 8'he8;
   localparam logic [7:0] LINK_CAP_TWO_OFS   = 8'hec;
   localparam logic [7:0] LINK_CTL_TWO_OFS   = 8'hf0;
   localparam logic [7:0] SLOT_CAP_TWO_OFS   = 8'hf4;
   localparam logic [7:0] SLOT_CTL_TWO_OFS   = 8'hf8;
   localparam logic [7:0] SLOT_CONTROL_OFS   = 8'h80;
   localparam logic [7:0] IRQ_STATUS_OFS     = 8'h84;
   localparam logic [7:0] IRQ_MASK_OFS       = 8'h88;

   // ****************************************************************
   // slot event state bits (full dword positions)
   // ****************************************************************
   localparam int BTN_BIT       = 16;
   localparam int PWR_FAULT_BIT = 17;
   localparam int LATCH_CHG_BIT = 18;
   localparam int PRES_CHG_BIT  = 19;
   localparam int CMD_DONE_BIT  = 20;
   localparam int LATCH_BIT     = 21;
   localparam int PRES_BIT      = 22;
   localparam int LINK_CHG_BIT  = 24;

   // slot control enables
   localparam int BTN_EN_BIT      = 0;
   localparam int PWR_FAULT_EN_BIT = 1;
   localparam int PRES_CHG_EN_BIT = 3;
   localparam int CMD_DONE_EN_BIT = 4;
   localparam int HP_IRQ_EN_BIT   = 5;
   localparam int LINK_CHG_EN_BIT = 12;

   // ****************************************************************
   // cap2 / control2 fields
   // ****************************************************************
   localparam logic [31:0] DEV_CAP_TWO_VAL   = 32'h0004_0800;
   localparam logic [15:0] DEV_CTL_TWO_MASK  = 16'h6400;
   localparam logic [15:0] LINK_CTL_TWO_MASK = 16'h1fbf;
   localparam logic [15:0] LINK_CTL_TWO_RST  = 16'h0002;
   localparam logic [15:0] SLOT_CTL_MASK     = 16'h173b;
   localparam logic [15:0] SLOT_CTL_RST      = 16'h03c0;
   localparam int          DEEMP_BIT         = 6;
   localparam int          HW_SPEED_DIS_BIT  = 5;
   localparam int          TGT_SPEED_MSB     = 3;
   localparam int          NUM_EVENTS        = 6;
   localparam int          LTR_EN_BIT        = 10;
   localparam int          OBFF_EN_LSB       = 13;

endpackage

/* File: hdl/slot_cap2_regs.sv */
// register slice: slot status events, device/link/slot cap2 registers, APB slave
`timescale 1ns/1ps

// Summary of operation
// RULE_01: attention button press sets bit 16; write one clears; resets zero.
// RULE_02: power fault sets bit 17; write one clears; resets zero.
// RULE_03: bit 18 latch sensor change, read-only, resets zero.
// RULE_04: presence change sets bit 19; write one clears; resets zero.
// RULE_05: command completion sets bit 20; write one clears; resets zero.
// RULE_06: bit 21 mirrors latch sensor: one open, zero closed.
// RULE_07: bit 22 shows card presence, read-only.
// RULE_08: with no slot implemented, presence bit reads one (the code forces it on downstream ports only).
// RULE_09: presence resets to inverse of the presence strap.
// RULE_10: link-active change sets bit 24; write one clears; resets one.
// RULE_11: device cap2 bit 11 reads one, other non-OBFF bits zero.
// RULE_12: device cap2 bits 19:18 read 01b.
// RULE_13: device control2 bits 14:13 and bit 10 read-write, reset zero.
// RULE_14: link control2 bit 6 read-only; zero upstream, one downstream.
// RULE_15: event interrupts need matching enable and global hot-plug enable (IRQ_OUT needs only its bit in the irq mask).
// RULE_16: reserved bits read zero and ignore writes.
module slot_cap2_regs
   import slot_cap2_pkg::*;
#(
   parameter bit DOWNSTREAM = 1'b1
)
(
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RST_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   input  wire logic [3:0]  PSTRB_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic        ATTN_BUTTON_IN,
   input  wire logic        POWER_FAULT_IN,
   input  wire logic        LATCH_OPEN_IN,
   input  wire logic        CARD_PRESENCE_STRAP_IN,
   input  wire logic        CARD_PRESENT_IN,
   input  wire logic        SLOT_IMPLEMENTED_IN,
   input  wire logic        CMD_DONE_IN,
   input  wire logic        LINK_ACTIVE_IN,
   output logic             HOTPLUG_IRQ_OUT,
   output logic             IRQ_OUT,
   output logic             LTR_ENABLE_OUT,
   output logic [1:0]       OBFF_ENABLE_OUT,
   output logic [3:0]       TARGET_SPEED_OUT,
   output logic             HW_SPEED_CHANGE_DISABLE_OUT
);

   // ****************************************************************
   // synchronisers for pins
   // ****************************************************************
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   logic [NSYNC-1:0] prev_reg;
   logic [NSYNC-1:0] pins;

   assign pins = {LINK_ACTIVE_IN, CMD_DONE_IN, SLOT_IMPLEMENTED_IN, CARD_PRESENT_IN,
                  CARD_PRESENCE_STRAP_IN, LATCH_OPEN_IN, POWER_FAULT_IN, ATTN_BUTTON_IN};

   // the pin pipeline has no reset: it keeps sampling while reset is held, so the
   // strap is settled at release and the edge history matches the pins (no false event)
   always_ff @(posedge CORE_CLK_IN)
   begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      prev_reg <= sync2_reg;
   end

   logic btn_s, pf_s, latch_s, strap_s, pres_s, slot_s, cmd_s, link_s;
   assign {link_s, cmd_s, slot_s, pres_s, strap_s, latch_s, pf_s, btn_s} = sync2_reg;

   // rising edges of pulse-like sources; changes of level sources
   function automatic logic rise(input logic now_val, input logic old_val);
      rise = now_val & ~old_val;
   endfunction

   function automatic logic moved(input logic now_val, input logic old_val);
      moved = now_val ^ old_val;
   endfunction

   logic btn_ev, pf_ev, cmd_ev, pres_ev, latch_ev, link_ev;
   assign btn_ev   = rise(btn_s, prev_reg[0]);
   assign pf_ev    = rise(pf_s, prev_reg[1]);
   assign latch_ev = moved(latch_s, prev_reg[2]);
   assign pres_ev  = moved(pres_s, prev_reg[4]);
   assign cmd_ev   = rise(cmd_s, prev_reg[6]);
   assign link_ev  = moved(link_s, prev_reg[7]);

   // ****************************************************************
   // apb decode
   // ****************************************************************
   logic access, wr, rd;
   assign access = PSEL_IN & PENABLE_IN & PREADY_OUT;
   assign wr     = access & PWRITE_IN;
   assign rd     = access & ~PWRITE_IN;

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // write data with disabled byte lanes forced to zero
   logic [31:0] wdata;
   assign wdata = PWDATA_IN & strb_mask(PSTRB_IN);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // byte-strobed update of the writable bits of a 16-bit register; the rest keeps its value
   function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                           input logic [15:0] new_val,
                                           input logic [1:0]  strb,
                                           input logic [15:0] wmask);
      logic [15:0] take;
      take    = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      merge16 = (new_val & take) | (old_val & ~take);
   endfunction

   // ****************************************************************
   // slot event flags
   // ****************************************************************
   logic btn_reg, pf_reg, latch_chg_reg, pres_chg_reg, cmd_reg, link_chg_reg;
   logic [15:0] slot_ctl_reg, dev_ctl_reg, link_ctl_reg;
   logic w1c_slot;
   assign w1c_slot = wr & hit(PADDR_IN, SLOT_EVENT_OFS);

   // set wins over a simultaneous write-one clear
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         btn_reg       <= 1'b0;  // [RULE_01]
         pf_reg        <= 1'b0;  // [RULE_02]
         latch_chg_reg <= 1'b0;  // [RULE_03]
         pres_chg_reg  <= 1'b0;  // [RULE_04]
         cmd_reg       <= 1'b0;  // [RULE_05]
         link_chg_reg  <= 1'b1;  // [RULE_10]
      end
      else
      begin
         btn_reg <= btn_ev | (btn_reg & ~(w1c_slot & wdata[BTN_BIT]));  // [RULE_01]
         pf_reg  <= pf_ev | (pf_reg & ~(w1c_slot & wdata[PWR_FAULT_BIT]));  // [RULE_02]
         // read-only: no software clear, so it only ever records that a change happened
         latch_chg_reg <= latch_ev | latch_chg_reg;  // [RULE_03]
         pres_chg_reg  <= pres_ev | (pres_chg_reg & ~(w1c_slot & wdata[PRES_CHG_BIT]));  // [RULE_04]
         cmd_reg  <= cmd_ev | (cmd_reg & ~(w1c_slot & wdata[CMD_DONE_BIT]));  // [RULE_05]
         link_chg_reg <= link_ev | (link_chg_reg & ~(w1c_slot & wdata[LINK_CHG_BIT]));  // [RULE_10]
      end
   end

   // presence state; reset value caught from the strap one cycle after release
   logic pres_reg, strap_taken_reg;
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         pres_reg        <= 1'b0;
         strap_taken_reg <= 1'b0;
      end
      else if (!strap_taken_reg)
      begin
         pres_reg        <= ~strap_s;  // [RULE_09]
         strap_taken_reg <= 1'b1;
      end
      else
         pres_reg <= pres_s;  // [RULE_07]
   end

   // a downstream port without a slot has no presence to sense, so software always sees a card
   logic pres_view;
   assign pres_view = (DOWNSTREAM && !slot_s) ? 1'b1 : pres_reg;  // [RULE_08]

   logic [31:0] slot_word;
   always_comb
   begin
      slot_word                = '0;  // [RULE_16]
      slot_word[15:0]          = slot_ctl_reg;
      slot_word[BTN_BIT]       = btn_reg;
      slot_word[PWR_FAULT_BIT] = pf_reg;
      slot_word[LATCH_CHG_BIT] = latch_chg_reg;
      slot_word[PRES_CHG_BIT]  = pres_chg_reg;
      slot_word[CMD_DONE_BIT]  = cmd_reg;
      slot_word[LATCH_BIT]     = latch_s;  // [RULE_06]
      slot_word[PRES_BIT]      = pres_view;
      slot_word[LINK_CHG_BIT]  = link_chg_reg;
   end

   // ****************************************************************
   // slot control (low half at the same dword) and control2 registers
   // ****************************************************************
   // de-emphasis select is fixed by port direction; writes never reach it
   logic [15:0] deemp_fixed;
   assign deemp_fixed = DOWNSTREAM ? (16'h0001 << DEEMP_BIT) : 16'h0000;

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
         slot_ctl_reg <= SLOT_CTL_RST;
      else if (wr && (hit(PADDR_IN, SLOT_EVENT_OFS) || hit(PADDR_IN, SLOT_CONTROL_OFS)))
         slot_ctl_reg <= merge16(slot_ctl_reg, PWDATA_IN[15:0], PSTRB_IN[1:0], SLOT_CTL_MASK);
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
         dev_ctl_reg <= 16'h0000;  // [RULE_13]
      else if (wr && hit(PADDR_IN, DEV_CTL_TWO_OFS))
         dev_ctl_reg <= merge16(dev_ctl_reg, PWDATA_IN[15:0], PSTRB_IN[1:0],
                                DEV_CTL_TWO_MASK);  // [RULE_13]
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
         link_ctl_reg <= LINK_CTL_TWO_RST;
      else if (wr && hit(PADDR_IN, LINK_CTL_TWO_OFS))
         link_ctl_reg <= merge16(link_ctl_reg, PWDATA_IN[15:0], PSTRB_IN[1:0],
                                 LINK_CTL_TWO_MASK);
   end

   logic [15:0] link_ctl_view;
   assign link_ctl_view = link_ctl_reg | deemp_fixed;  // [RULE_14]

   // ****************************************************************
   // interrupts
   // ****************************************************************
   logic [NUM_EVENTS-1:0] events, irq_stat_reg, irq_mask_reg;
   assign events = {link_ev, cmd_ev, pres_ev, latch_ev, pf_ev, btn_ev};

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
         irq_stat_reg <= '0;
      else if (rd && hit(PADDR_IN, IRQ_STATUS_OFS))
         // clear only what the read returned; an event after the data was captured stays set
         irq_stat_reg <= events | (irq_stat_reg & ~PRDATA_OUT[NUM_EVENTS-1:0]);
      else
         irq_stat_reg <= irq_stat_reg | events;
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
         irq_mask_reg <= '0;
      // mask write takes the low byte only; the events sit in its low bits
      else if (wr && hit(PADDR_IN, IRQ_MASK_OFS) && PSTRB_IN[0])
         irq_mask_reg <= PWDATA_IN[NUM_EVENTS-1:0];
   end

   // latch change has no enable bit of its own, so it never raises the hot-plug line
   logic hp_req;
   assign hp_req = slot_ctl_reg[HP_IRQ_EN_BIT] &
                   ((btn_reg & slot_ctl_reg[BTN_EN_BIT]) |
                    (pf_reg & slot_ctl_reg[PWR_FAULT_EN_BIT]) |
                    (pres_chg_reg & slot_ctl_reg[PRES_CHG_EN_BIT]) |
                    (cmd_reg & slot_ctl_reg[CMD_DONE_EN_BIT]) |
                    (link_chg_reg & slot_ctl_reg[LINK_CHG_EN_BIT]));  // [RULE_15]

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         HOTPLUG_IRQ_OUT <= 1'b0;
         IRQ_OUT         <= 1'b0;
      end
      else
      begin
         HOTPLUG_IRQ_OUT <= hp_req;  // [RULE_15]
         IRQ_OUT         <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ****************************************************************
   // read mux and bus answer (no wait state: setup, then ready)
   // ****************************************************************
   logic [31:0] rdata;
   logic        mapped;
   always_comb
   begin
      rdata  = '0;
      mapped = 1'b1;
      case (PADDR_IN)
         SLOT_EVENT_OFS:   rdata = slot_word;
         DEV_CAP_TWO_OFS:  rdata = DEV_CAP_TWO_VAL;  // [RULE_11] [RULE_12]
         DEV_CTL_TWO_OFS:  rdata = {16'h0000, dev_ctl_reg};
         LINK_CAP_TWO_OFS: rdata = '0;
         LINK_CTL_TWO_OFS: rdata = {16'h0000, link_ctl_view};
         SLOT_CAP_TWO_OFS: rdata = '0;
         SLOT_CTL_TWO_OFS: rdata = '0;
         SLOT_CONTROL_OFS: rdata = {16'h0000, slot_ctl_reg};
         IRQ_STATUS_OFS:   rdata = {{(32-NUM_EVENTS){1'b0}}, irq_stat_reg};
         IRQ_MASK_OFS:     rdata = {{(32-NUM_EVENTS){1'b0}}, irq_mask_reg};
         default:          mapped = 1'b0;
      endcase
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         PREADY_OUT  <= 1'b0;
         PRDATA_OUT  <= '0;
         PSLVERR_OUT <= 1'b0;
      end
      else
      begin
         PREADY_OUT  <= PSEL_IN & ~PENABLE_IN;
         PRDATA_OUT  <= (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) ? rdata : 32'h0000_0000;
         // unmapped addresses answer with an error and zero data; writes to them are dropped
         PSLVERR_OUT <= PSEL_IN & ~PENABLE_IN & ~mapped;
      end
   end

   // ****************************************************************
   // control outputs
   // ****************************************************************
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (RST_IN)
      begin
         LTR_ENABLE_OUT              <= 1'b0;
         OBFF_ENABLE_OUT             <= 2'b00;
         TARGET_SPEED_OUT            <= 4'h0;
         HW_SPEED_CHANGE_DISABLE_OUT <= 1'b0;
      end
      else
      begin
         // registered copies run one cycle behind the control registers they mirror
         LTR_ENABLE_OUT              <= dev_ctl_reg[LTR_EN_BIT];
         OBFF_ENABLE_OUT             <= dev_ctl_reg[OBFF_EN_LSB+1:OBFF_EN_LSB];
         TARGET_SPEED_OUT            <= link_ctl_reg[TGT_SPEED_MSB:0];
         HW_SPEED_CHANGE_DISABLE_OUT <= link_ctl_reg[HW_SPEED_DIS_BIT];
      end
   end

endmodule // slot_cap2_regs

/* File: verification/slot_cap2_regs_asserts.sv */
// concurrent checks on the ports of the slot status and cap2 register slice
`timescale 1ns/1ps

module slot_cap2_regs_asserts
   import slot_cap2_pkg::*;
#(
   parameter bit DOWNSTREAM = 1'b1
)
(
   input wire logic        CORE_CLK_IN,
   input wire logic        RST_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PWRITE_IN,
   input wire logic [7:0]  PADDR_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PREADY_OUT,
   input wire logic        SLOT_IMPLEMENTED_IN,
   input wire logic        LTR_ENABLE_OUT,
   input wire logic [1:0]  OBFF_ENABLE_OUT
);
   // ****************************************************************
   // helpers
   // ****************************************************************
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (RST_IN);

   // device control2 outputs may only move after a completed write to that register
   wire wr_ctl2 = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == DEV_CTL_TWO_OFS;
   wire rd_zero = PSEL_IN && !PENABLE_IN && !PWRITE_IN
                  && (PADDR_IN == LINK_CAP_TWO_OFS || PADDR_IN == SLOT_CAP_TWO_OFS
                      || PADDR_IN == SLOT_CTL_TWO_OFS);

   sequence s_rd(logic [7:0] a);
      PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == a;
   endsequence

   // ****************************************************************
   // properties
   // ****************************************************************
   property p_cap_read;
      s_rd(DEV_CAP_TWO_OFS) |=> PRDATA_OUT == 32'h0004_0800;
   endproperty
   property p_cap_obff;
      s_rd(DEV_CAP_TWO_OFS) |=> PRDATA_OUT[19:18] == 2'b01;
   endproperty
   property p_ctl2_read;
      s_rd(DEV_CTL_TWO_OFS) |=> (PRDATA_OUT & 32'hffff_9bff) == 32'h0;
   endproperty
   property p_ltr_src;
      $changed(LTR_ENABLE_OUT) |-> $past(wr_ctl2, 1) || $past(wr_ctl2, 2);
   endproperty
   property p_obff_src;
      $changed(OBFF_ENABLE_OUT) |-> $past(wr_ctl2, 1) || $past(wr_ctl2, 2);
   endproperty
   property p_deemp;
      s_rd(LINK_CTL_TWO_OFS) |=> PRDATA_OUT[6] == DOWNSTREAM && PRDATA_OUT[31:13] == 19'h0;
   endproperty
   property p_zero_regs;
      rd_zero |=> PRDATA_OUT == 32'h0;
   endproperty
   property p_slot_resv;
      s_rd(SLOT_EVENT_OFS) |=> PRDATA_OUT[31:25] == 7'h0 && !PRDATA_OUT[23];
   endproperty
   property p_no_slot;
      s_rd(SLOT_EVENT_OFS) ##0 (!SLOT_IMPLEMENTED_IN && !$past(SLOT_IMPLEMENTED_IN, 4))
         |=> PRDATA_OUT[22];
   endproperty

   a_cap_read: assert property (p_cap_read) else $error("device cap2 read wrong");
   a_cap_obff: assert property (p_cap_obff) else $error("obff support field wrong");
   a_ctl2_read: assert property (p_ctl2_read) else $error("control2 fixed bits set");
   a_ltr_src: assert property (p_ltr_src) else $error("ltr enable moved alone");
   a_obff_src: assert property (p_obff_src) else $error("obff enable moved alone");
   a_deemp: assert property (p_deemp) else $error("de-emphasis bit wrong");
   a_zero_regs: assert property (p_zero_regs) else $error("zero register not zero");
   a_slot_resv: assert property (p_slot_resv) else $error("slot reserved bit set");
   a_no_slot: assert property (p_no_slot) else $error("presence not forced");
endmodule // slot_cap2_regs_asserts

bind slot_cap2_regs slot_cap2_regs_asserts #(.DOWNSTREAM(DOWNSTREAM)) u_asserts (
   .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
   .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
   .PREADY_OUT(PREADY_OUT), .SLOT_IMPLEMENTED_IN(SLOT_IMPLEMENTED_IN),
   .LTR_ENABLE_OUT(LTR_ENABLE_OUT), .OBFF_ENABLE_OUT(OBFF_ENABLE_OUT));

/* File: verification/test_slot_cap2_regs.sv */
// self-checking bench for the slot status and cap2 register slice
`timescale 1ns/1ps

module test_slot_cap2_regs;
   import slot_cap2_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'h0, tspeed;
   logic        pready, pslverr, err, hp_irq, irq, ltr, hwdis;
   logic [1:0]  obff;
   logic        attn = 1'b0, pfault = 1'b0, latch = 1'b0, strap = 1'b0, card = 1'b1;
   logic        slot_impl = 1'b1, cmd_done = 1'b0, link_act = 1'b0;
   int          n_fail = 0, check_count = 0;

   always #2 clk = ~clk;

   slot_cap2_regs dut (
      .CORE_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .ATTN_BUTTON_IN(attn), .POWER_FAULT_IN(pfault), .LATCH_OPEN_IN(latch),
      .CARD_PRESENCE_STRAP_IN(strap), .CARD_PRESENT_IN(card),
      .SLOT_IMPLEMENTED_IN(slot_impl), .CMD_DONE_IN(cmd_done), .LINK_ACTIVE_IN(link_act),
      .HOTPLUG_IRQ_OUT(hp_irq), .IRQ_OUT(irq), .LTR_ENABLE_OUT(ltr), .OBFF_ENABLE_OUT(obff),
      .TARGET_SPEED_OUT(tspeed), .HW_SPEED_CHANGE_DISABLE_OUT(hwdis));

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         n_fail++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(what, rd, exp);
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_chk("slot dword", SLOT_EVENT_OFS, 32'h0140_03c0);
      rd_chk("dev cap2", DEV_CAP_TWO_OFS, 32'h0004_0800);
      rd_chk("dev ctl2", DEV_CTL_TWO_OFS, 32'h0);
      rd_chk("link ctl2", LINK_CTL_TWO_OFS, 32'h0000_0042);
      rd_chk("slot cap2", SLOT_CAP_TWO_OFS, 32'h0);
      $display("test reset values done");
      apb(1'b1, DEV_CTL_TWO_OFS, 32'hffff_ffff, 4'hf);
      rd_chk("dev ctl2 ones", DEV_CTL_TWO_OFS, 32'h0000_6400);
      chk("ltr enable", ltr, 32'h1);
      chk("obff enable", obff, 32'h3);
      apb(1'b1, DEV_CTL_TWO_OFS, 32'h0, 4'hf);
      rd_chk("dev ctl2 zero", DEV_CTL_TWO_OFS, 32'h0);
      apb(1'b1, LINK_CTL_TWO_OFS, 32'hffff_ffff, 4'hf);
      rd_chk("link ctl2 ones", LINK_CTL_TWO_OFS, 32'h0000_1fff);
      chk("speed disable", {tspeed, hwdis}, 32'h1f);
      apb(1'b1, LINK_CTL_TWO_OFS, 32'h0, 4'hf);
      rd_chk("link ctl2 zero", LINK_CTL_TWO_OFS, 32'h0000_0040);
      apb(1'b1, DEV_CAP_TWO_OFS, 32'hffff_ffff, 4'hf);
      rd_chk("dev cap2 kept", DEV_CAP_TWO_OFS, 32'h0004_0800);
      apb(1'b1, LINK_CAP_TWO_OFS, 32'hffff_ffff, 4'hf);
      rd_chk("link cap2", LINK_CAP_TWO_OFS, 32'h0);
      rd_chk("unmapped", 8'h40, 32'h0);
      chk("unmapped error", err, 32'h1);
      $display("test control registers done");
      apb(1'b1, IRQ_MASK_OFS, 32'h0, 4'hf);
      @(posedge clk);
      attn <= 1'b1;
      pfault <= 1'b1;
      cmd_done <= 1'b1;
      latch <= 1'b1;
      card <= 1'b0;
      link_act <= 1'b1;
      repeat (3) @(posedge clk);
      attn <= 1'b0;
      pfault <= 1'b0;
      cmd_done <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk("events set", SLOT_EVENT_OFS, 32'h013f_03c0);
      chk("masked irq", irq, 32'h0);
      rd_chk("irq status", IRQ_STATUS_OFS, 32'h0000_003f);
      rd_chk("irq status cleared", IRQ_STATUS_OFS, 32'h0);
      apb(1'b1, SLOT_EVENT_OFS, 32'hffff_0000, 4'hc);
      rd_chk("events cleared", SLOT_EVENT_OFS, 32'h0024_03c0);
      $display("test slot events done");
      apb(1'b1, IRQ_MASK_OFS, 32'h1, 4'hf);
      apb(1'b1, SLOT_EVENT_OFS, 32'h0000_0001, 4'h3);
      @(posedge clk);
      attn <= 1'b1;
      repeat (3) @(posedge clk);
      attn <= 1'b0;
      repeat (6) @(posedge clk);
      chk("irq on", irq, 32'h1);
      chk("hotplug without global", hp_irq, 32'h0);
      apb(1'b1, SLOT_EVENT_OFS, 32'h0000_0021, 4'h3);
      repeat (3) @(posedge clk);
      chk("hotplug on", hp_irq, 32'h1);
      rd_chk("irq status one", IRQ_STATUS_OFS, 32'h1);
      repeat (3) @(posedge clk);
      chk("irq off", irq, 32'h0);
      apb(1'b1, SLOT_EVENT_OFS, 32'h0001_0000, 4'h4);
      repeat (3) @(posedge clk);
      chk("hotplug off", hp_irq, 32'h0);
      $display("test interrupts done");
      slot_impl <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk("no slot presence", SLOT_EVENT_OFS, 32'h0064_00e1);
      $display("test no slot done");
      slot_impl <= 1'b1;
      card <= 1'b1;
      strap <= 1'b1;
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_chk("strap presence", SLOT_EVENT_OFS, 32'h0120_03c0);
      rd_chk("card presence", SLOT_EVENT_OFS, 32'h0160_03c0);
      $display("test strap reset done");
      stop_test();
   end
endmodule // test_slot_cap2_regs
